/* inc/acsq_params.svh */
// constants of the converter autosequencer control block
// assumes aclk at 100 MHz and a converter clock derived from it
`ifndef ACSQ_PARAMS_SVH
`define ACSQ_PARAMS_SVH

// timing
`define ACSQ_CLK_MHZ      100
`define ACSQ_ADC_CLK_MHZ  25
`define ACSQ_CONV_NS      80
`define ACSQ_CONV_TICKS   ((`ACSQ_CONV_NS * `ACSQ_ADC_CLK_MHZ) / 1000)
`define ACSQ_DIV_RST      (`ACSQ_CLK_MHZ / `ACSQ_ADC_CLK_MHZ - 1)
`define ACSQ_CODE_MAX     12'hFFF

// register byte offsets; CHSEL and RESULT give only the upper address bits of their windows
`define ACSQ_OFS_CTRL     8'h00
`define ACSQ_OFS_CMD      8'h04
`define ACSQ_OFS_MAXCONV  8'h08
`define ACSQ_OFS_PRESC    8'h0C
`define ACSQ_OFS_CHSEL    4'h1
`define ACSQ_OFS_STATUS   8'h20
`define ACSQ_OFS_RESULT   2'h1

// control bits of converter_control_third
`define ACSQ_B_CASCADE    0
`define ACSQ_B_STARTSTOP  1
`define ACSQ_B_IRQALT0    2
`define ACSQ_B_EVEN0      4
`define ACSQ_B_ROUTE0     6
`define ACSQ_B_EXTREF     8

// bus responses
`define ACSQ_RESP_OKAY    2'h0
`define ACSQ_RESP_SLVERR  2'h2
`endif

/* inc/acsq_pkg.sv */
// types of the converter autosequencer control block
// assumes acsq_params.svh for all numeric constants
package acsq_pkg;
	// converter sequencing states, one-hot
	typedef enum logic [3:0] {
		CV_IDLE  = 4'h1,
		CV_ACQ   = 4'h2,
		CV_CONV  = 4'h4,
		CV_STORE = 4'h8
	} acsq_cv_t;

	// whole state of the block
	typedef struct packed {
		logic             awready, wready, bvalid, arready, rvalid;
		logic [1:0]       bresp, rresp;
		logic [31:0]      rdata;
		logic             aw_have, w_have;
		logic [7:0]       awaddr;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             halt_s1, halt_s2, cke_s1, cke_s2;
		logic [1:0]       pin_s1, pin_s2;
		logic [13:0]      raw_s1, raw_s2;
		logic [15:0]      ctrl;
		logic [7:0]       maxconv;
		logic [7:0]       presc;
		logic [15:0][3:0] chsel;
		logic [15:0][11:0] result;
		logic [1:0]       busy, tog, irq, soc_out, trip;
		logic [1:0][3:0]  ptr;
		acsq_cv_t         cv;
		logic             owner;
		logic [3:0]       slot, chan, div_cnt, cnt;
		logic             power_down, sample_hold;
	} acsq_state_t;
endpackage

/* rtl/acsq_top.sv */
// converter autosequencer control: two 8-slot or one 16-slot sequencer,
// one shared converter, sixteen results, AXI4-Lite register slave
// assumes trigger inputs are one-cycle pulses on aclk; pins are asynchronous
//
// Summary of operation
// RULE_01: results saturate to 0 and 4095
// RULE_02: conversion takes 80 ns at 25 MHz
// RULE_03: up to sixteen slots, any channel each
// RULE_04: two 8-slot sequencers or one cascaded
// RULE_05: dual mode restricts each sequencer's channel group
// RULE_06: one converter serves both sequencers serially
// RULE_07: each conversion stored in its slot's result
// RULE_08: software or either event manager triggers
// RULE_09: event manager triggers start sequencers independently
// RULE_10: interrupt every end of sequence or every second
// RULE_11: start/stop mode converts one slot per trigger
// RULE_12: acquisition window has its own prescaler
// RULE_13: registers on system clock, conversion on peripheral
// RULE_14: reset defaults registers, analog held powered down
// RULE_15: clock enable low blocks writes and conversions
// RULE_16: host waits settling time after enabling clock
// RULE_17: halt powers analog down, registers kept
// RULE_18: halt freezes conversion logic
// RULE_19: software sets external reference bit at power-up
// RULE_20: event starts routable to shared start pins
// RULE_21: cascade fills slots in order; busy ignores triggers
`include "acsq_params.svh"
`timescale 1ns/1ns
`default_nettype none

module acsq_top (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// axi4-lite write response
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// axi4-lite read
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// clock enable and halt pins
	input  wire logic        converter_register_clock_enable,
	input  wire logic        halt_request,
	// event manager start triggers
	input  wire logic        event_manager_first_soc,
	input  wire logic        event_manager_second_soc,
	// shared start / compare-trip pins
	input  wire logic        first_mgr_conv_start_pin_in,
	output logic             first_mgr_conv_start_pin_out,
	output logic             first_mgr_conv_start_pin_oe,
	input  wire logic        second_mgr_conv_start_pin_in,
	output logic             second_mgr_conv_start_pin_out,
	output logic             second_mgr_conv_start_pin_oe,
	output logic             timer_two_compare_trip,
	output logic             timer_four_compare_trip,
	// analog core
	input  wire logic [13:0] analog_code_raw,
	output logic             analog_power_down,
	output logic             sample_hold,
	output logic [3:0]       conv_channel,
	output logic             ext_ref_select,
	// end of sequence interrupt requests
	output logic [1:0]       end_of_sequence_irq
);
	import acsq_pkg::*;

	localparam logic [3:0] CONV_LAST = 4'(`ACSQ_CONV_TICKS - 1);
	localparam logic [3:0] DIV_RST   = 4'(`ACSQ_DIV_RST);

	acsq_state_t st;
	acsq_state_t nx;
	logic [11:0] sat_code;

	// RULE_01 clamp raw code
	// bit 13 marks a code below zero, bit 12 one above range
	assign sat_code = st.raw_s2[13] ? 12'h000 :
		(st.raw_s2[12] ? `ACSQ_CODE_MAX : st.raw_s2[11:0]);

	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, nw, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// next-state logic of the whole block
	always_comb begin
		logic        run, do_wr, wr_hit, rd_hit, tick, g, last, casc;
		logic [31:0] wr, rd;
		logic [3:0]  cmd, base, top;
		logic [1:0]  trig;
		run    = 1'b0;
		do_wr  = 1'b0;
		wr_hit = 1'b0;
		rd_hit = 1'b0;
		tick   = 1'b0;
		g      = 1'b0;
		last   = 1'b0;
		casc   = st.ctrl[`ACSQ_B_CASCADE];
		wr     = 32'h0000_0000;
		rd     = 32'h0000_0000;
		cmd    = 4'h0;
		trig   = 2'h0;
		base   = 4'h0;
		top    = 4'h0;
		nx     = st;

		// two-flop synchronisers for pins
		nx.halt_s1 = halt_request;
		nx.halt_s2 = st.halt_s1;
		nx.cke_s1  = converter_register_clock_enable;
		nx.cke_s2  = st.cke_s1;
		nx.pin_s1  = {second_mgr_conv_start_pin_in, first_mgr_conv_start_pin_in};
		nx.pin_s2  = st.pin_s1;
		nx.raw_s1  = analog_code_raw;
		nx.raw_s2  = st.raw_s1;

		// RULE_13 peripheral clock gated
		run = st.cke_s2 && !st.halt_s2;
		// RULE_17 analog powered only when enabled
		nx.power_down = !run;
		nx.irq = 2'h0;

		// RULE_20 route starts to pins
		nx.soc_out = {event_manager_second_soc, event_manager_first_soc};
		nx.trip[0] = st.ctrl[`ACSQ_B_ROUTE0] ? 1'b0 : st.pin_s2[0];
		nx.trip[1] = st.ctrl[`ACSQ_B_ROUTE0 + 1] ? 1'b0 : st.pin_s2[1];

		// write address and data are taken in either order
		if (awvalid && st.awready) begin
			nx.aw_have = 1'b1;
			nx.awaddr  = awaddr;
		end
		if (wvalid && st.wready) begin
			nx.w_have = 1'b1;
			nx.wdata  = wdata;
			nx.wstrb  = wstrb;
		end
		do_wr  = st.aw_have && st.w_have && !st.bvalid;
		wr_hit = (st.awaddr == `ACSQ_OFS_CTRL) || (st.awaddr == `ACSQ_OFS_CMD) ||
			(st.awaddr == `ACSQ_OFS_MAXCONV) || (st.awaddr == `ACSQ_OFS_PRESC) ||
			(st.awaddr[7:4] == `ACSQ_OFS_CHSEL && st.awaddr[1:0] == 2'h0);
		if (do_wr) begin
			nx.aw_have = 1'b0;
			nx.w_have  = 1'b0;
			nx.bvalid  = 1'b1;
			nx.bresp   = wr_hit ? `ACSQ_RESP_OKAY : `ACSQ_RESP_SLVERR;
		end
		if (st.bvalid && bready) begin
			nx.bvalid = 1'b0;
		end
		nx.awready = !nx.aw_have && !nx.bvalid;
		nx.wready  = !nx.w_have && !nx.bvalid;

		// RULE_15 writes land only while enabled
		if (do_wr && st.cke_s2) begin
			if (st.awaddr == `ACSQ_OFS_CTRL) begin
				wr = merge({16'h0000, st.ctrl}, st.wdata, st.wstrb);
				nx.ctrl = {7'h00, wr[8:0]};
			end else if (st.awaddr == `ACSQ_OFS_CMD) begin
				cmd = st.wstrb[0] ? st.wdata[3:0] : 4'h0;
			end else if (st.awaddr == `ACSQ_OFS_MAXCONV) begin
				wr = merge({24'h000000, st.maxconv}, st.wdata, st.wstrb);
				nx.maxconv = {1'b0, wr[6:0]};
			end else if (st.awaddr == `ACSQ_OFS_PRESC) begin
				wr = merge({24'h000000, st.presc}, st.wdata, st.wstrb);
				nx.presc = wr[7:0];
			end else if (st.awaddr[7:4] == `ACSQ_OFS_CHSEL) begin
				wr = merge({16'h0000, st.chsel[{st.awaddr[3:2], 2'h3}],
					st.chsel[{st.awaddr[3:2], 2'h2}], st.chsel[{st.awaddr[3:2], 2'h1}],
					st.chsel[{st.awaddr[3:2], 2'h0}]},
					{16'h0000, st.wdata[15:0]}, st.wstrb);
				for (int k = 0; k < 4; k++) begin
					nx.chsel[{st.awaddr[3:2], 2'(k)}] = wr[4*k +: 4];
				end
			end
		end

		// read decode; status and results read in any state
		if (araddr == `ACSQ_OFS_CTRL) begin
			rd = {16'h0000, st.ctrl};
			rd_hit = 1'b1;
		end else if (araddr == `ACSQ_OFS_CMD) begin
			rd_hit = 1'b1;
		end else if (araddr == `ACSQ_OFS_MAXCONV) begin
			rd = {24'h000000, st.maxconv};
			rd_hit = 1'b1;
		end else if (araddr == `ACSQ_OFS_PRESC) begin
			rd = {24'h000000, st.presc};
			rd_hit = 1'b1;
		end else if (araddr[7:4] == `ACSQ_OFS_CHSEL && araddr[1:0] == 2'h0) begin
			rd = {16'h0000, st.chsel[{araddr[3:2], 2'h3}], st.chsel[{araddr[3:2], 2'h2}],
				st.chsel[{araddr[3:2], 2'h1}], st.chsel[{araddr[3:2], 2'h0}]};
			rd_hit = 1'b1;
		end else if (araddr == `ACSQ_OFS_STATUS) begin
			rd = {12'h000, st.ptr[1], st.ptr[0], st.chan, st.cv, st.owner, st.busy,
				st.power_down};
			rd_hit = 1'b1;
		end else if (araddr[7:6] == `ACSQ_OFS_RESULT && araddr[1:0] == 2'h0) begin
			rd = {20'h00000, st.result[araddr[5:2]]};
			rd_hit = 1'b1;
		end
		if (arvalid && st.arready) begin
			nx.arready = 1'b0;
			nx.rvalid  = 1'b1;
			nx.rdata   = rd;
			nx.rresp   = rd_hit ? `ACSQ_RESP_OKAY : `ACSQ_RESP_SLVERR;
		end
		if (st.rvalid && rready) begin
			nx.rvalid  = 1'b0;
			nx.arready = 1'b1;
		end

		// RULE_08 trigger sources
		// RULE_09 independent in dual mode
		trig[0] = cmd[0] || (st.ctrl[`ACSQ_B_EVEN0] && event_manager_first_soc) ||
			(casc && st.ctrl[`ACSQ_B_EVEN0 + 1] && event_manager_second_soc);
		trig[1] = !casc && (cmd[1] ||
			(st.ctrl[`ACSQ_B_EVEN0 + 1] && event_manager_second_soc));
		for (int i = 0; i < 2; i++) begin
			// idle pointer reset by command
			if (cmd[2 + i] && !st.busy[i]) begin
				nx.ptr[i] = (i == 1) ? 4'h8 : 4'h0;
			end
			// RULE_21 busy sequencer ignores trigger
			if (run && trig[i] && !st.busy[i]) begin
				nx.busy[i] = 1'b1;
			end
		end

		// RULE_18 whole converter path frozen unless running
		if (run) begin
			// RULE_02 converter clock prescaler
			tick = (st.div_cnt == 4'h0);
			nx.div_cnt = tick ? st.presc[3:0] : st.div_cnt - 4'h1;
			case (st.cv)
				CV_IDLE: begin
					// RULE_06 seq zero wins ties
					if (st.busy[0] || st.busy[1]) begin
						g = !st.busy[0];
						nx.owner = g;
						nx.slot  = st.ptr[g];
						// RULE_05 dual mode channel group
						// RULE_03 any of sixteen channels
						nx.chan = casc ? st.chsel[st.ptr[g]] : {g, st.chsel[st.ptr[g]][2:0]};
						nx.cv = CV_ACQ;
						// RULE_12 acquisition window count
						nx.cnt = st.presc[7:4];
						nx.div_cnt = st.presc[3:0];
						nx.sample_hold = 1'b1;
					end
				end
				CV_ACQ: begin
					if (tick) begin
						if (st.cnt == 4'h0) begin
							nx.cv = CV_CONV;
							nx.cnt = CONV_LAST;
							nx.div_cnt = st.presc[3:0];
							nx.sample_hold = 1'b0;
						end else begin
							nx.cnt = st.cnt - 4'h1;
						end
					end
				end
				CV_CONV: begin
					if (tick) begin
						if (st.cnt == 4'h0) begin
							nx.cv = CV_STORE;
						end else begin
							nx.cnt = st.cnt - 4'h1;
						end
					end
				end
				CV_STORE: begin
					// RULE_07 result by slot
					nx.result[st.slot] = sat_code;
					g = st.owner;
					// RULE_04 slot range per mode
					base = g ? 4'h8 : 4'h0;
					top = casc ? st.maxconv[3:0] : base | {1'b0, st.maxconv[4*g +: 3]};
					last = (st.ptr[g] == top) || (st.ptr[g] == 4'hF);
					if (last) begin
						nx.ptr[g] = base;
						nx.busy[g] = 1'b0;
						nx.tog[g] = !st.tog[g];
						// RULE_10 every or every other
						nx.irq[g] = !st.ctrl[`ACSQ_B_IRQALT0 + 32'(g)] || st.tog[g];
					end else begin
						// RULE_21 slots advance in order
						nx.ptr[g] = st.ptr[g] + 4'h1;
						// RULE_11 start/stop pauses
						nx.busy[g] = !st.ctrl[`ACSQ_B_STARTSTOP];
					end
					nx.cv = CV_IDLE;
				end
				default: begin
					nx.cv = CV_IDLE;
				end
			endcase
		end
	end

	// state register; RULE_14 every field to default
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st            <= '0;
			st.awready    <= 1'b1;
			st.wready     <= 1'b1;
			st.arready    <= 1'b1;
			st.presc      <= {4'h0, DIV_RST};
			st.ptr[1]     <= 4'h8;
			st.cv         <= CV_IDLE;
			st.power_down <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	// outputs straight from the state register
	assign awready  = st.awready;
	assign wready   = st.wready;
	assign bvalid   = st.bvalid;
	assign bresp    = st.bresp;
	assign arready  = st.arready;
	assign rvalid   = st.rvalid;
	assign rdata    = st.rdata;
	assign rresp    = st.rresp;
	assign first_mgr_conv_start_pin_out  = st.soc_out[0];
	assign first_mgr_conv_start_pin_oe   = st.ctrl[`ACSQ_B_ROUTE0];
	assign second_mgr_conv_start_pin_out = st.soc_out[1];
	assign second_mgr_conv_start_pin_oe  = st.ctrl[`ACSQ_B_ROUTE0 + 1];
	assign timer_two_compare_trip  = st.trip[0];
	assign timer_four_compare_trip = st.trip[1];
	assign analog_power_down   = st.power_down;
	assign sample_hold         = st.sample_hold;
	assign conv_channel        = st.chan;
	assign ext_ref_select      = st.ctrl[`ACSQ_B_EXTREF];
	assign end_of_sequence_irq = st.irq;

	// checks of the design's own behaviour
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_sat_high: assert property ( // RULE_01
		(st.cv == CV_STORE && !st.raw_s2[13] && st.raw_s2[12] && st.cke_s2 && !st.halt_s2)
		|=> st.result[$past(st.slot)] == 12'hFFF)
		else $error("over-range code not clamped to full scale");
	a_conv_time: assert property ( // RULE_02
		($rose(st.cv == CV_CONV) && st.presc[3:0] == 4'h3) |-> (st.cv == CV_CONV)[*8])
		else $error("conversion shorter than eight cycles");
	a_dual_group: assert property ( // RULE_05
		(st.cv != CV_IDLE && !st.ctrl[`ACSQ_B_CASCADE] && $stable(st.ctrl))
		|-> st.chan[3] == st.owner)
		else $error("sequencer left its channel group");
	a_store_slot: assert property ( // RULE_07
		(st.cv == CV_STORE && st.cke_s2 && !st.halt_s2)
		|=> st.result[$past(st.slot)] == $past(sat_code))
		else $error("result not written to its slot");
	a_irq_pulse: assert property ( // RULE_10
		st.irq[0] |-> $past(st.cv == CV_STORE) ##1 !st.irq[0])
		else $error("end of sequence request not a single pulse");
	a_gate_write: assert property ( // RULE_15
		(!st.cke_s2 && st.aw_have && st.w_have && !st.bvalid) |=> $stable(st.ctrl))
		else $error("register written while clock disabled");
	a_halt_power: assert property ( // RULE_17
		st.halt_s2 |=> st.power_down ##0 $stable(st.ctrl))
		else $error("halt did not power analog down");
	a_halt_freeze: assert property ( // RULE_18
		(st.halt_s2 && st.cv != CV_IDLE) |=> $stable(st.cv) && $stable(st.cnt))
		else $error("converter advanced during halt");
	a_casc_order: assert property ( // RULE_21
		(st.cv == CV_STORE && st.ctrl[`ACSQ_B_CASCADE] && $stable(st.ctrl))
		|-> st.slot == st.ptr[0])
		else $error("cascade slot out of order");
	a_reset_pwrdn: assert property (@(posedge aclk) disable iff (1'b0) // RULE_14
		!aresetn |=> st.power_down && st.cv == CV_IDLE)
		else $error("reset left analog powered");
endmodule

`default_nettype wire

/* tb/acsq_analog_model.sv */
// behavioural analog core for the autosequencer bench
// assumes the block holds conv_channel steady through each conversion
`timescale 1ns/1ns
`default_nettype none
module acsq_analog_model (
	// clock
	input  wire logic        aclk,
	// control from the block
	input  wire logic [3:0]  conv_channel,
	input  wire logic        sample_hold,
	input  wire logic        analog_power_down,
	// converter code
	output logic [13:0]      analog_code_raw
);
	function automatic logic [13:0] code_of(input logic [3:0] c);
		if (c == 4'h0) return 14'h3F00;
		if (c == 4'h1) return 14'h1800;
		return {2'b00, c * 12'h111};
	endfunction
	// code settles in acquisition, held through conversion
	// a powered-down core has no valid code, so the line toggles
	always @(posedge aclk) begin
		if (analog_power_down)
			analog_code_raw <= ~analog_code_raw;
		else if (sample_hold)
			analog_code_raw <= code_of(conv_channel);
	end
	initial analog_code_raw = 14'h0000;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the converter autosequencer control
// assumes acsq_top with inline assertions and the analog model beside it
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	// bus master and pin drivers
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        cke, halt, soc1, soc2, pin1, pin2;
	// design outputs
	wire logic        awready, wready, bvalid, arready, rvalid, pd, sh, xref;
	wire logic        oe1, oe2, po1, po2, trip2, trip4;
	wire logic [1:0]  bresp, rresp, irq;
	wire logic [31:0] rdata;
	wire logic [13:0] raw;
	wire logic [3:0]  chan;
	// bookkeeping
	int          n_mismatch, comparisons, n_irq0, sh_cnt, sh_len, seed, k, base;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	logic [3:0]  ch[16];
	logic [31:0] word;

	acsq_top i_acsq_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.converter_register_clock_enable(cke), .halt_request(halt),
		.event_manager_first_soc(soc1), .event_manager_second_soc(soc2),
		.first_mgr_conv_start_pin_in(pin1), .first_mgr_conv_start_pin_out(po1),
		.first_mgr_conv_start_pin_oe(oe1), .second_mgr_conv_start_pin_in(pin2),
		.second_mgr_conv_start_pin_out(po2), .second_mgr_conv_start_pin_oe(oe2),
		.timer_two_compare_trip(trip2), .timer_four_compare_trip(trip4),
		.analog_code_raw(raw), .analog_power_down(pd), .sample_hold(sh),
		.conv_channel(chan), .ext_ref_select(xref), .end_of_sequence_irq(irq));
	acsq_analog_model i_acsq_analog_model (.aclk(aclk), .conv_channel(chan),
		.sample_hold(sh), .analog_power_down(pd), .analog_code_raw(raw));

	// clock, 10 ns period
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// expected code: saturates below zero and above range
	function automatic logic [11:0] exp_code(input logic [3:0] c);
		if (c == 4'h0) return 12'h000;
		if (c == 4'h1) return 12'hFFF;
		return c * 12'h111;
	endfunction

	// write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		bq.push_back(e);
		awaddr <= a; wdata <= d; wstrb <= 4'hF;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			// bready stays up: the next call raises it in this same time step
			if (bvalid) break;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		rq.push_back({e, d});
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			// rready stays up: the next call raises it in this same time step
			if (rvalid) break;
		end
	endtask

	task automatic wait_irq(input int b);
		for (int t = 0; t < 3000; t++) begin
			@(posedge aclk);
			if (irq[b] === 1'b1) break;
		end
		// a request that never came counts against the run
		chk(34'(irq[b]), 34'h1);
	endtask

	// monitor: oldest note against each response, acquisition window length
	always @(posedge aclk) begin
		if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
		if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
		if (irq[0] === 1'b1) n_irq0++;
		if (sh === 1'b1) sh_cnt++;
		else if (sh_cnt != 0) begin
			if (sh_len != 0) chk(34'(sh_cnt), 34'(sh_len));
			sh_cnt = 0;
		end
	end

	// watchdog: whole run needs well under two thousand cycles
	initial begin
		repeat (30000) @(posedge aclk);
		n_mismatch++;
		summarize();
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, cke, halt, soc1, soc2} = '0;
		{pin1, pin2, awaddr, araddr, wdata, wstrb} = '0;
		n_mismatch = 0; comparisons = 0; n_irq0 = 0; sh_cnt = 0;
		sh_len = 4; seed = 72; aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// defaults, unmapped read, disabled writes ignored
		rd(8'h0C, 32'h3, 2'h0);
		rd(8'h24, 32'h0, 2'h2);
		chk(34'(pd), 34'h1);
		wr(8'h00, 32'h100, 2'h0);
		rd(8'h00, 32'h0, 2'h0);
		// enable, then a shortened settling wait
		cke <= 1'b1;
		repeat (20) @(posedge aclk);
		chk(34'(pd), 34'h0);
		wr(8'h00, 32'h100, 2'h0);
		rd(8'h00, 32'h100, 2'h0);
		chk(34'(xref), 34'h1);
		wr(8'h40, 32'h5, 2'h2);
		// cascade: sixteen slots, random channels, two saturating ones
		for (k = 0; k < 16; k++) ch[k] = 4'($random(seed));
		ch[0] = 4'h0;
		ch[1] = 4'h1;
		for (k = 0; k < 4; k++) begin
			word = {16'h0, ch[4*k+3], ch[4*k+2], ch[4*k+1], ch[4*k]};
			wr(8'h10 + 8'(4*k), word, 2'h0);
		end
		wr(8'h08, 32'hF, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		wr(8'h04, 32'h1, 2'h0);
		wait_irq(0);
		for (k = 0; k < 16; k++) rd(8'h40 + 8'(4*k), {20'h0, exp_code(ch[k])}, 2'h0);
		// dual mode, both managers at once, longer acquisition
		wr(8'h10, 32'hE, 2'h0);
		wr(8'h18, 32'h4B, 2'h0);
		wr(8'h08, 32'h10, 2'h0);
		wr(8'h0C, 32'h13, 2'h0);
		sh_len = 8;
		wr(8'h00, 32'h30, 2'h0);
		soc1 <= 1'b1; soc2 <= 1'b1;
		@(posedge aclk);
		soc1 <= 1'b0; soc2 <= 1'b0;
		wait_irq(0);
		wait_irq(1);
		rd(8'h40, 32'h666, 2'h0);
		rd(8'h60, 32'hBBB, 2'h0);
		rd(8'h64, 32'hCCC, 2'h0);
		// starts routed to both shared pins, trip inputs driven high meanwhile
		wr(8'h00, 32'hD0, 2'h0);
		chk(34'(oe1), 34'h1);
		chk(34'(oe2), 34'h1);
		soc1 <= 1'b1;
		soc2 <= 1'b1;
		pin1 <= 1'b1;
		pin2 <= 1'b1;
		@(posedge aclk);
		soc1 <= 1'b0;
		soc2 <= 1'b0;
		// pin copies of the starts stand for the cycle after the trigger
		@(posedge aclk);
		chk(34'(po1), 34'h1);
		chk(34'(po2), 34'h1);
		@(posedge aclk);
		chk(34'(chan), 34'h6);
		wait_irq(0);
		chk(34'(trip2), 34'h0);
		chk(34'(trip4), 34'h0);
		wr(8'h00, 32'h0, 2'h0);
		repeat (4) @(posedge aclk);
		chk(34'(trip2), 34'h1);
		chk(34'(trip4), 34'h1);
		// second start while busy is ignored
		base = n_irq0;
		wr(8'h04, 32'h1, 2'h0);
		wr(8'h04, 32'h1, 2'h0);
		repeat (80) @(posedge aclk);
		chk(34'(n_irq0 - base), 34'h1);
		// interrupt on every second end of sequence
		wr(8'h00, 32'h4, 2'h0);
		base = n_irq0;
		for (k = 0; k < 4; k++) begin
			wr(8'h04, 32'h1, 2'h0);
			repeat (60) @(posedge aclk);
		end
		chk(34'(n_irq0 - base), 34'h2);
		// start/stop: one slot per trigger
		wr(8'h08, 32'h1, 2'h0);
		wr(8'h00, 32'h2, 2'h0);
		base = n_irq0;
		wr(8'h04, 32'h1, 2'h0);
		repeat (60) @(posedge aclk);
		chk(34'(n_irq0 - base), 34'h0);
		// pointer reset while paused: slot 0 converts again, still no end
		wr(8'h04, 32'h4, 2'h0);
		wr(8'h04, 32'h1, 2'h0);
		repeat (60) @(posedge aclk);
		chk(34'(n_irq0 - base), 34'h0);
		wr(8'h04, 32'h1, 2'h0);
		repeat (60) @(posedge aclk);
		chk(34'(n_irq0 - base), 34'h1);
		// second sequencer by software start, one slot long
		wr(8'h04, 32'h2, 2'h0);
		wait_irq(1);
		// halt mid-conversion: analog down, logic frozen, registers kept
		wr(8'h08, 32'h0, 2'h0);
		wr(8'h00, 32'h0, 2'h0);
		sh_len = 0;
		base = n_irq0;
		wr(8'h04, 32'h1, 2'h0);
		repeat (12) @(posedge aclk);
		halt <= 1'b1;
		repeat (40) @(posedge aclk);
		chk(34'(pd), 34'h1);
		chk(34'(n_irq0 - base), 34'h0);
		rd(8'h08, 32'h0, 2'h0);
		halt <= 1'b0;
		repeat (60) @(posedge aclk);
		chk(34'(n_irq0 - base), 34'h1);
		summarize();
	end
endmodule
`default_nettype wire
